/* File: hdl/hcrh_regs.svh */
/*
  Constants for the host cycle ready handshake block.
  Assumes a single 25 MHz clock and a synchronous active-high reset.
*/
// Function
// - With the latch-enable flavour selected the handshake pin is an active-low ready output.
// - With the address-strobe flavour selected the handshake pin is an active-low transfer acknowledge output.
// - During a cycle the handshake output stays high and goes low only once the cycle can complete.
// - In hardware-strap mode the handshake pin is an input that commands receive muting on loss of signal.
// - In the latch-enable flavour the address is latched on the falling edge of the latch-enable input.
`ifndef HCRH_REGS_SVH
`define HCRH_REGS_SVH

`define HCRH_TYPE_LATCH 2'h0
`define HCRH_TYPE_STROBE 2'h1
`define HCRH_ADDR_WIDTH 7
`define HCRH_ACCESS_NS 80
`define HCRH_CLK_NS 40
`define HCRH_ACCESS_CYCLES ((`HCRH_ACCESS_NS + `HCRH_CLK_NS - 1) / `HCRH_CLK_NS)

`endif

/* File: hdl/hcrh_pkg.sv */
/*
  Types for the host cycle ready handshake block.
  Assumes hcrh_regs.svh is available on the include path.
*/
package hcrh_pkg;
    typedef enum logic [1:0] {hcrh_idle, hcrh_wait, hcrh_ack, hcrh_done} hcrh_state_type;
endpackage : hcrh_pkg

/* File: hdl/hcrh_sync.sv */
/*
  Three-stage input synchroniser with a second/third stage agreement filter.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module hcrh_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Raw and clean level
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    always_comb
    begin
        next_stage = {stage[1:0], pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage <= 3'h0;
            level <= 1'h0;
        end
        else
        begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule : hcrh_sync

/* File: hdl/hcrh_top.sv */
/*
  Cycle-completion handshake of the asynchronous host port.
  Assumes host pins are asynchronous; all but the address bus pass through hcrh_sync; the
  pin wire level is resolved outside from the enable.
*/
`timescale 1ns/1ps
`include "hcrh_regs.svh"
module hcrh_top
    import hcrh_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Mode straps
    input wire logic host_mode,
    input wire logic [1:0] host_interface_type_select,
    // Host cycle pins
    input wire logic chip_select_n,
    input wire logic address_latch_or_strobe_input,
    input wire logic [`HCRH_ADDR_WIDTH-1:0] address_bus,
    // Handshake pin
    input wire logic cycle_complete_handshake_pin_in,
    output logic cycle_complete_handshake_pin_out,
    output logic cycle_complete_handshake_pin_oe,
    // Internal side
    output logic [`HCRH_ADDR_WIDTH-1:0] latched_address,
    output logic cycle_start,
    output logic receive_silence_on_signal_loss_input
);
    logic cs_active;
    logic cs_active_pin;
    logic ale_level;
    logic mute_level;
    logic ale_prev;
    logic next_ale_prev;
    logic [`HCRH_ADDR_WIDTH-1:0] next_latched_address;
    logic next_cycle_start;
    hcrh_state_type state;
    hcrh_state_type next_state;
    logic [1:0] count;
    logic [1:0] next_count;
    logic hs_out;
    logic next_hs_out;
    logic latch_flavour;
    logic strobe_flavour;
    logic in_cycle;

    // Chip select is inverted ahead of the synchroniser so its zero reset value reads as no cycle;
    // syncing the raw pin would show a phantom cycle for the first edges after reset
    assign cs_active_pin = !chip_select_n;
    hcrh_sync u_cs (.clk(clk), .reset(reset), .pin(cs_active_pin), .level(cs_active));
    hcrh_sync u_ale (.clk(clk), .reset(reset), .pin(address_latch_or_strobe_input), .level(ale_level));
    hcrh_sync u_mute (.clk(clk), .reset(reset), .pin(cycle_complete_handshake_pin_in), .level(mute_level));

    assign latch_flavour = host_interface_type_select == `HCRH_TYPE_LATCH;
    assign strobe_flavour = host_interface_type_select == `HCRH_TYPE_STROBE;
    // Strobe flavour needs the strobe low as well; latch flavour only chip select
    assign in_cycle = host_mode && cs_active && (latch_flavour || (strobe_flavour && !ale_level));

    // Address capture; the bus is assumed stable around the strobe edge
    always_comb
    begin
        next_ale_prev = ale_level;
        next_latched_address = latched_address;
        next_cycle_start = 1'h0;
        if (host_mode && latch_flavour && ale_prev && !ale_level)
        begin
            next_latched_address = address_bus;
            next_cycle_start = 1'h1;
        end
        else if (host_mode && strobe_flavour && ale_prev && !ale_level)
        begin
            next_latched_address = address_bus;
            next_cycle_start = 1'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ale_prev <= 1'h0;
            latched_address <= '0;
            cycle_start <= 1'h0;
        end
        else
        begin
            ale_prev <= next_ale_prev;
            latched_address <= next_latched_address;
            cycle_start <= next_cycle_start;
        end
    end

    // Handshake sequencer; output is high until the access time elapses
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_hs_out = 1'h1;
        case (state)
            hcrh_idle:
            begin
                next_count = 2'h0;
                if (in_cycle)
                begin
                    next_state = hcrh_wait;
                end
            end
            hcrh_wait:
            begin
                next_count = count + 2'h1;
                if (!in_cycle)
                begin
                    next_state = hcrh_idle;
                end
                else if (count == 2'(`HCRH_ACCESS_CYCLES - 1))
                begin
                    next_state = hcrh_ack;
                    next_hs_out = 1'h0;
                end
            end
            hcrh_ack:
            begin
                next_hs_out = 1'h0;
                if (!cs_active || !host_mode)
                begin
                    next_state = hcrh_done;
                    next_hs_out = 1'h1;
                end
            end
            hcrh_done:
            begin
                next_state = hcrh_idle;
            end
            default:
            begin
                next_state = hcrh_idle;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= hcrh_idle;
            count <= 2'h0;
            hs_out <= 1'h1;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            hs_out <= next_hs_out;
        end
    end

    // Same active-low pin whether it acts as ready or as acknowledge
    assign cycle_complete_handshake_pin_out = hs_out;
    assign cycle_complete_handshake_pin_oe = host_mode;
    assign receive_silence_on_signal_loss_input = !host_mode && mute_level;

    property p_low_needs_cycle;
        @(posedge clk) disable iff (reset)
        !cycle_complete_handshake_pin_out |-> $past(in_cycle);
    endproperty
    a_low_needs_cycle: assert property (p_low_needs_cycle) else $error("handshake low outside a cycle");

    property p_ack_timing;
        @(posedge clk) disable iff (reset)
        (state == hcrh_idle && in_cycle) ##1 in_cycle [*2] |=> !cycle_complete_handshake_pin_out;
    endproperty
    a_ack_timing: assert property (p_ack_timing) else $error("handshake late");

    property p_not_early;
        @(posedge clk) disable iff (reset)
        (state == hcrh_idle && in_cycle) |=> cycle_complete_handshake_pin_out [*2];
    endproperty
    a_not_early: assert property (p_not_early) else $error("handshake early");

    property p_release;
        @(posedge clk) disable iff (reset)
        (state == hcrh_ack && !cs_active) |=> cycle_complete_handshake_pin_out;
    endproperty
    a_release: assert property (p_release) else $error("handshake not released");

    property p_strap_input;
        @(posedge clk) disable iff (reset)
        !host_mode |-> !cycle_complete_handshake_pin_oe;
    endproperty
    a_strap_input: assert property (p_strap_input) else $error("pin driven in strap mode");

    property p_mute_follow;
        @(posedge clk) disable iff (reset)
        receive_silence_on_signal_loss_input |-> !host_mode && mute_level;
    endproperty
    a_mute_follow: assert property (p_mute_follow) else $error("mute output wrong");

    property p_latch;
        @(posedge clk) disable iff (reset)
        (host_mode && latch_flavour && ale_prev && !ale_level) |=> cycle_start && latched_address == $past(address_bus);
    endproperty
    a_latch: assert property (p_latch) else $error("address not latched");

    property p_driven_host;
        @(posedge clk) disable iff (reset)
        host_mode && (latch_flavour || strobe_flavour) |-> cycle_complete_handshake_pin_oe;
    endproperty
    a_driven_host: assert property (p_driven_host) else $error("handshake not driven");

    property p_abort;
        @(posedge clk) disable iff (reset)
        (state == hcrh_wait && !in_cycle) |=> state == hcrh_idle && cycle_complete_handshake_pin_out;
    endproperty
    a_abort: assert property (p_abort) else $error("dropped cycle not abandoned");

    property p_strap_quiet;
        @(posedge clk) disable iff (reset)
        !host_mode |=> cycle_complete_handshake_pin_out;
    endproperty
    a_strap_quiet: assert property (p_strap_quiet) else $error("handshake low in strap mode");

    property p_strap_no_start;
        @(posedge clk) disable iff (reset)
        !host_mode |=> !cycle_start;
    endproperty
    a_strap_no_start: assert property (p_strap_no_start) else $error("cycle start in strap mode");
endmodule : hcrh_top

/* File: verif/hcrh_host_model.sv */
/* Host processor model for hcrh_top: runs stretched register cycles.
   Assumes the bench resolves the handshake wire and feeds it back. */
`timescale 1ns/1ps
`include "hcrh_regs.svh"
module hcrh_host_model
(
    // Clock
    input wire logic clk,
    // Host pins
    output logic chip_select_n,
    output logic strobe,
    output logic [`HCRH_ADDR_WIDTH-1:0] address_bus,
    input wire logic handshake
);
    initial
    begin
        chip_select_n = 1'h1;
        strobe = 1'h0;
        address_bus = '0;
    end
    // Strobe is raised first so either flavour sees a falling edge
    task run(input logic strobe_flavour, input logic [`HCRH_ADDR_WIDTH-1:0] a, output int waited);
        @(posedge clk) #1;
        address_bus = a;
        strobe = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        strobe = 1'h0;
        chip_select_n = 1'h0;
        waited = 0;
        @(posedge clk) #1;
        while (handshake !== 1'h0 && waited < 40)
        begin
            @(posedge clk) #1;
            waited++;
        end
        chip_select_n = 1'h1;
        strobe = strobe_flavour;
        address_bus = ~a;
    endtask : run
    task abort_cycle(input int n);
        @(posedge clk) #1;
        chip_select_n = 1'h0;
        repeat (n) @(posedge clk);
        #1;
        chip_select_n = 1'h1;
    endtask : abort_cycle
endmodule : hcrh_host_model

/* File: verif/testbench.sv */
/* Self-checking bench for hcrh_top with a host model on its pins.
   Assumes the design's own assertions guard the cycle-level timing. */
`timescale 1ns/1ps
`include "hcrh_regs.svh"
module testbench;
    logic clk, reset, host_mode, chip_select_n, strobe, strap_drv, pin;
    logic pin_out, pin_oe, cycle_start, mute;
    logic [1:0] type_sel;
    logic [`HCRH_ADDR_WIDTH-1:0] address_bus, latched_address, a;
    logic [`HCRH_ADDR_WIDTH-1:0] expect_q[$];
    int bad_count = 0, comparisons = 0, cycles = 0, seed = 19375, waited, low_count = 0, low_mark = 0, rnd;
    // Pin follows strap_drv when the design does not drive it
    assign pin = pin_oe ? pin_out : strap_drv;
    hcrh_top uut (.clk(clk), .reset(reset), .host_mode(host_mode), .host_interface_type_select(type_sel),
        .chip_select_n(chip_select_n), .address_latch_or_strobe_input(strobe), .address_bus(address_bus),
        .cycle_complete_handshake_pin_in(pin), .cycle_complete_handshake_pin_out(pin_out),
        .cycle_complete_handshake_pin_oe(pin_oe), .latched_address(latched_address),
        .cycle_start(cycle_start), .receive_silence_on_signal_loss_input(mute));
    hcrh_host_model host (.clk(clk), .chip_select_n(chip_select_n), .strobe(strobe),
        .address_bus(address_bus), .handshake(pin));
    task check(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : check
    task stop_test;
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (pin_out === 1'h0)
            low_count++;
        if (cycle_start === 1'h1)
        begin
            if (expect_q.size() == 0)
                check("cycle_start", 8'h0, 8'h1);
            else
                check("latched_address", expect_q.pop_front(), latched_address);
        end
        if (cycles == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end
    initial
    begin
        reset = 1'h1;
        host_mode = 1'h1;
        type_sel = `HCRH_TYPE_LATCH;
        strap_drv = 1'h0;
        repeat (12) @(posedge clk);
        #1 reset = 1'h0;
        repeat (4) @(posedge clk);
        for (int f = 0; f < 2; f++)
        begin
            #1 type_sel = f ? `HCRH_TYPE_STROBE : `HCRH_TYPE_LATCH;
            for (int i = 0; i < 4; i++)
            begin
                rnd = $random(seed);
                a = rnd[`HCRH_ADDR_WIDTH-1:0];
                expect_q.push_back(a);
                check("idle handshake", 8'h1, pin);
                host.run(f[0], a, waited);
                check("ack seen", 8'h1, waited < 40);
                check("ack not early", 8'h1, waited >= 3);
                repeat (6) @(posedge clk);
                #1 check("handshake released", 8'h1, pin);
            end
        end
        // Chip select held for two cycles is seen by the sequencer but dropped before the access time
        #1 type_sel = `HCRH_TYPE_LATCH;
        low_mark = low_count;
        host.abort_cycle(2);
        repeat (12) @(posedge clk);
        #1 check("aborted handshake", 8'h0, 8'(low_count - low_mark));
        type_sel = 2'h2;
        low_mark = low_count;
        host.abort_cycle(20);
        repeat (8) @(posedge clk);
        #1 check("unknown flavour handshake", 8'h0, 8'(low_count - low_mark));
        check("host mode drive", 8'h1, pin_oe);
        check("pending addresses", 8'h0, 8'(expect_q.size()));
        host_mode = 1'h0;
        for (int i = 0; i < 6; i++)
        begin
            rnd = $random(seed);
            #1 strap_drv = rnd[0];
            repeat (5) @(posedge clk);
            #1 check("mute command", strap_drv, mute);
            check("strap mode drive", 8'h0, pin_oe);
        end
        stop_test();
    end
endmodule : testbench
